/* File: cct_pkg.sv */
package cct_pkg;

  // Register indices as printed; the APB byte address is four times the index
  localparam int unsigned    CCT_ADDR_W     = 12;
  localparam logic [9:0]     CCT_IDX_MSTBY  = 10'h008;
  localparam logic [9:0]     CCT_IDX_MODE   = 10'h120;
  localparam logic [9:0]     CCT_IDX_CTRL1  = 10'h121;
  localparam logic [9:0]     CCT_IDX_IEN    = 10'h122;
  localparam logic [9:0]     CCT_IDX_FLAGS  = 10'h123;
  localparam logic [9:0]     CCT_IDX_IOAB   = 10'h124;
  localparam logic [9:0]     CCT_IDX_IOCD   = 10'h125;
  localparam logic [9:0]     CCT_IDX_CNT    = 10'h126;
  localparam logic [9:0]     CCT_IDX_GRA    = 10'h128;
  localparam logic [9:0]     CCT_IDX_GRB    = 10'h12a;
  localparam logic [9:0]     CCT_IDX_GRC    = 10'h12c;
  localparam logic [9:0]     CCT_IDX_GRD    = 10'h12e;
  // Range that the standby bit locks out
  localparam logic [9:0]     CCT_IDX_LO     = 10'h120;
  localparam logic [9:0]     CCT_IDX_HI     = 10'h133;

  // Reset values
  localparam logic [7:0]     CCT_RST_MSTBY  = 8'h00;
  localparam logic [7:0]     CCT_RST_MODE   = 8'h48;
  localparam logic [7:0]     CCT_RST_CTRL1  = 8'h00;
  localparam logic [7:0]     CCT_RST_IEN    = 8'h70;
  localparam logic [7:0]     CCT_RST_IOAB   = 8'h80;
  localparam logic [7:0]     CCT_RST_IOCD   = 8'h88;

  // Unassigned bits, read as one except in standby, when reads of these registers return zero
  localparam logic [7:0]     CCT_ONES_MODE  = 8'h40;
  localparam logic [7:0]     CCT_ONES_IEN   = 8'h70;
  localparam logic [7:0]     CCT_ONES_FLAGS = 8'h70;
  localparam logic [7:0]     CCT_ONES_IOAB  = 8'h80;

  // Field positions
  localparam int unsigned    CCT_B_SLEEP    = 5;
  localparam int unsigned    CCT_B_W2N      = 3;
  localparam int unsigned    CCT_B_BUFC     = 4;
  localparam int unsigned    CCT_B_BUFD     = 5;
  localparam int unsigned    CCT_B_RUN      = 7;
  localparam int unsigned    CCT_B_SRC_LO   = 4;
  localparam int unsigned    CCT_B_COUNTER_CLEAR_SEL     = 7;
  localparam int unsigned    CCT_B_WRAP     = 7;
  localparam int unsigned    CCT_B_CAPSEL0  = 2;
  localparam int unsigned    CCT_B_CAPSRC   = 3;
  localparam int unsigned    CCT_B_CAPSEL1  = 6;
  localparam int unsigned    CCT_B_ROLE0    = 3;
  localparam int unsigned    CCT_B_ROLE1    = 7;
  localparam int unsigned    CCT_B_EDGE1    = 4;

  // Count source codes
  localparam logic [2:0]     CCT_SRC_F1     = 3'h0;
  localparam logic [2:0]     CCT_SRC_F2     = 3'h1;
  localparam logic [2:0]     CCT_SRC_F4     = 3'h2;
  localparam logic [2:0]     CCT_SRC_F8     = 3'h3;
  localparam logic [2:0]     CCT_SRC_F32    = 3'h4;
  localparam logic [2:0]     CCT_SRC_EXT    = 3'h5;

  // Capture edge codes
  localparam logic [1:0]     CCT_EDGE_RISE  = 2'h0;
  localparam logic [1:0]     CCT_EDGE_FALL  = 2'h1;

  localparam logic [15:0]    CCT_CNT_TOP    = 16'hffff;
  localparam logic [4:0]     CCT_DIV_ONE    = 5'h01;
  localparam logic [15:0]    CCT_CNT_ONE    = 16'h0001;

endpackage : cct_pkg

/* File: cct_timer_ctrl.sv */
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps

module cct_timer_ctrl
  import cct_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [CCT_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  ext_count_clock_pin,
  input  wire logic                  channel_a_pin,
  input  wire logic                  channel_b_pin,
  input  wire logic                  channel_c_pin,
  input  wire logic                  channel_d_pin,
  input  wire logic                  slow_osc_div_signal,
  output logic                       chan_a_irq,
  output logic                       chan_b_irq,
  output logic                       chan_c_irq,
  output logic                       chan_d_irq,
  output logic                       wrap_irq,
  output logic                       timer_clock_on
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0]  mstby_ff, nxt_mstby;
  logic [7:0]  mode_ff, nxt_mode;
  logic [7:0]  ctrl1_ff, nxt_ctrl1;
  logic [7:0]  ien_ff, nxt_ien;
  logic [7:0]  ioab_ff, nxt_ioab;
  logic [7:0]  iocd_ff, nxt_iocd;
  logic [4:0]  flags_ff, nxt_flags;
  logic [4:0]  armed_ff, nxt_armed;
  logic [15:0] cnt_ff, nxt_cnt;
  logic [15:0] gr_ff [4];
  logic [15:0] nxt_gr [4];
  logic [4:0]  div_ff, nxt_div;
  logic [5:0]  sync1_ff, nxt_sync1;
  logic [5:0]  sync2_ff, nxt_sync2;
  logic [5:0]  prev_ff, nxt_prev;
  logic [31:0] prdata_ff, nxt_prdata;
  logic        pready_ff, nxt_pready;
  logic        pslverr_ff, nxt_pslverr;
  logic [4:0]  irq_ff, nxt_irq;
  logic        clk_on_ff, nxt_clk_on;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  function automatic logic hit(input logic [CCT_ADDR_W-1:0] a, input logic [9:0] idx);
    hit = (a[CCT_ADDR_W-1:2] == idx);
  endfunction : hit

  function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic was);
    logic rise;
    logic fall;
    rise = now & ~was;
    fall = ~now & was;
    unique case (sel)
      CCT_EDGE_RISE: edge_hit = rise;
      CCT_EDGE_FALL: edge_hit = fall;
      default:       edge_hit = rise | fall;
    endcase
  endfunction : edge_hit

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel configuration
  logic       sleeping;
  logic       running;
  logic       tick;
  logic [3:0] timer_ch;
  logic [3:0] cap_en;
  logic [3:0] cmp_en;
  logic [3:0] cap_hit;
  logic [3:0] match;
  logic [3:0] role_ok;
  logic [3:0] pin_now;
  logic [3:0] pin_was;
  logic [1:0] edge_sel [4];
  logic [3:0] cap_sel;
  logic       ext_rise;
  logic       wrap_ev;
  logic       clr_cnt;

  assign sleeping = mstby_ff[CCT_B_SLEEP];
  // Stopping all activity stands in for the gated clock, so no clock gate is needed
  assign running  = mode_ff[CCT_B_RUN] & ~sleeping;

  assign cap_sel     = {iocd_ff[CCT_B_CAPSEL1], iocd_ff[CCT_B_CAPSEL0],
                        ioab_ff[CCT_B_CAPSEL1], ioab_ff[CCT_B_CAPSEL0]};
  assign edge_sel[0] = ioab_ff[1:0];
  assign edge_sel[1] = ioab_ff[CCT_B_EDGE1+1:CCT_B_EDGE1];
  assign edge_sel[2] = iocd_ff[1:0];
  assign edge_sel[3] = iocd_ff[CCT_B_EDGE1+1:CCT_B_EDGE1];
  // Role bit low keeps C or D as an output holding register, out of compare/capture in timer mode
  assign role_ok     = {iocd_ff[CCT_B_ROLE1], iocd_ff[CCT_B_ROLE0], 2'b11};

  // Channel A may capture the slow oscillator signal instead of its pin
  assign pin_now = {sync2_ff[3:1],
                    ioab_ff[CCT_B_CAPSRC] ? sync2_ff[0] : sync2_ff[5]};
  assign pin_was = {prev_ff[3:1],
                    ioab_ff[CCT_B_CAPSRC] ? prev_ff[0] : prev_ff[5]};
  assign ext_rise = sync2_ff[4] & ~prev_ff[4];

  // Channel A has no pulse bit; it runs in timer mode only while WAVEFORM2_SELECT_N is set
  assign timer_ch[0] = mode_ff[CCT_B_W2N];

  genvar gi;
  generate
    for (gi = 1; gi < 4; gi++) begin : g_mode
      assign timer_ch[gi] = mode_ff[CCT_B_W2N] & ~mode_ff[gi-1];
    end
    for (gi = 0; gi < 4; gi++) begin : g_chan
      assign cap_en[gi]  = timer_ch[gi] & cap_sel[gi] & role_ok[gi];
      assign cap_hit[gi] = running & cap_en[gi] &
                           edge_hit(edge_sel[gi], pin_now[gi], pin_was[gi]);
      // Pulse modes ignore the I/O control bits, so those channels always compare
      assign cmp_en[gi]  = ~timer_ch[gi] | (~cap_sel[gi] & role_ok[gi]);
      // Buffered C/D still compare against the counter
      assign match[gi]   = tick & cmp_en[gi] & (cnt_ff == gr_ff[gi]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Count source
  always_comb begin
    unique case (ctrl1_ff[CCT_B_SRC_LO+2:CCT_B_SRC_LO])
      CCT_SRC_F1:  tick = running;
      CCT_SRC_F2:  tick = running & div_ff[0];
      CCT_SRC_F4:  tick = running & (&div_ff[1:0]);
      CCT_SRC_F8:  tick = running & (&div_ff[2:0]);
      CCT_SRC_F32: tick = running & (&div_ff);
      CCT_SRC_EXT: tick = running & ext_rise;
      default:     tick = 1'b0;
    endcase
  end

  assign wrap_ev = tick & (cnt_ff == CCT_CNT_TOP);
  assign clr_cnt = ctrl1_ff[CCT_B_COUNTER_CLEAR_SEL] & (cap_hit[0] | match[0]);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic        access;
  logic        done;
  logic        in_range;
  logic        blocked;
  logic        mapped;
  logic        wr_ok;
  logic        rd_ok;
  logic [4:0]  clr_mask;
  logic [15:0] rd16;

  assign access   = psel & penable;
  assign done     = access & pready_ff;
  assign in_range = (paddr[CCT_ADDR_W-1:2] >= CCT_IDX_LO) &&
                    (paddr[CCT_ADDR_W-1:2] <= CCT_IDX_HI);
  assign blocked  = sleeping & in_range;
  assign mapped   = hit(paddr, CCT_IDX_MSTBY) | hit(paddr, CCT_IDX_MODE) |
                    hit(paddr, CCT_IDX_CTRL1) | hit(paddr, CCT_IDX_IEN)  |
                    hit(paddr, CCT_IDX_FLAGS) | hit(paddr, CCT_IDX_IOAB) |
                    hit(paddr, CCT_IDX_IOCD)  | hit(paddr, CCT_IDX_CNT)  |
                    hit(paddr, CCT_IDX_GRA)   | hit(paddr, CCT_IDX_GRB)  |
                    hit(paddr, CCT_IDX_GRC)   | hit(paddr, CCT_IDX_GRD);

  // Refused accesses neither store nor arm, so a locked timer keeps its state
  assign wr_ok    = done & pwrite & ~blocked;
  assign rd_ok    = done & ~pwrite & ~blocked;

  // Only flags that were returned as one are armed for clearing
  assign clr_mask = (wr_ok & hit(paddr, CCT_IDX_FLAGS)) ?
                    (armed_ff & ~{pwdata[CCT_B_WRAP], pwdata[3:0]}) : 5'h00;

  always_comb begin
    rd16 = 16'h0000;
    if (hit(paddr, CCT_IDX_MSTBY)) rd16 = {8'h00, mstby_ff};
    if (hit(paddr, CCT_IDX_MODE))  rd16 = {8'h00, mode_ff | CCT_ONES_MODE};
    if (hit(paddr, CCT_IDX_CTRL1)) rd16 = {8'h00, ctrl1_ff};
    if (hit(paddr, CCT_IDX_IEN))   rd16 = {8'h00, ien_ff | CCT_ONES_IEN};
    if (hit(paddr, CCT_IDX_FLAGS)) rd16 = {8'h00, flags_ff[4], 3'b000,
                                           flags_ff[3:0]} | {8'h00, CCT_ONES_FLAGS};
    if (hit(paddr, CCT_IDX_IOAB))  rd16 = {8'h00, ioab_ff | CCT_ONES_IOAB};
    if (hit(paddr, CCT_IDX_IOCD))  rd16 = {8'h00, iocd_ff};
    if (hit(paddr, CCT_IDX_CNT))   rd16 = cnt_ff;
    if (hit(paddr, CCT_IDX_GRA))   rd16 = gr_ff[0];
    if (hit(paddr, CCT_IDX_GRB))   rd16 = gr_ff[1];
    if (hit(paddr, CCT_IDX_GRC))   rd16 = gr_ff[2];
    if (hit(paddr, CCT_IDX_GRD))   rd16 = gr_ff[3];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_mstby   = mstby_ff;
    nxt_mode    = mode_ff;
    nxt_ctrl1   = ctrl1_ff;
    nxt_ien     = ien_ff;
    nxt_ioab    = ioab_ff;
    nxt_iocd    = iocd_ff;
    nxt_cnt     = cnt_ff;
    nxt_gr      = gr_ff;
    nxt_armed   = armed_ff;
    nxt_div     = running ? div_ff + CCT_DIV_ONE : 5'h00;

    // Counter and general register hardware updates
    if (clr_cnt) begin
      nxt_cnt = 16'h0000;
    end else if (tick) begin
      nxt_cnt = cnt_ff + CCT_CNT_ONE;
    end
    for (int i = 0; i < 4; i++) begin
      if (cap_hit[i]) begin
        nxt_gr[i] = cnt_ff;
      end
    end
    // Buffer pairs: capture shifts the old value down, compare reloads from the buffer
    if (mode_ff[CCT_B_BUFC]) begin
      if (cap_hit[0]) nxt_gr[2] = gr_ff[0];
      if (match[0]) nxt_gr[0] = gr_ff[2];
    end
    if (mode_ff[CCT_B_BUFD]) begin
      if (cap_hit[1]) nxt_gr[3] = gr_ff[1];
      if (match[1]) nxt_gr[1] = gr_ff[3];
    end

    // A read of the flags arms exactly the bits returned as one
    if (rd_ok & hit(paddr, CCT_IDX_FLAGS)) begin
      nxt_armed = {prdata_ff[CCT_B_WRAP], prdata_ff[3:0]};
    end

    // Software writes take effect on the completing edge; software wins over hardware, except that a new flag event wins over a flag clear
    if (wr_ok) begin
      if (hit(paddr, CCT_IDX_MSTBY)) nxt_mstby = pwdata[7:0];
      if (hit(paddr, CCT_IDX_MODE))  nxt_mode  = pwdata[7:0] & ~CCT_ONES_MODE;
      if (hit(paddr, CCT_IDX_CTRL1)) nxt_ctrl1 = pwdata[7:0];
      if (hit(paddr, CCT_IDX_IEN))   nxt_ien   = pwdata[7:0] & ~CCT_ONES_IEN;
      if (hit(paddr, CCT_IDX_FLAGS)) nxt_armed = 5'h00;
      if (hit(paddr, CCT_IDX_IOAB))  nxt_ioab  = pwdata[7:0] & ~CCT_ONES_IOAB;
      if (hit(paddr, CCT_IDX_IOCD))  nxt_iocd  = pwdata[7:0];
      if (hit(paddr, CCT_IDX_CNT))   nxt_cnt   = pwdata[15:0];
      if (hit(paddr, CCT_IDX_GRA))   nxt_gr[0] = pwdata[15:0];
      if (hit(paddr, CCT_IDX_GRB))   nxt_gr[1] = pwdata[15:0];
      if (hit(paddr, CCT_IDX_GRC))   nxt_gr[2] = pwdata[15:0];
      if (hit(paddr, CCT_IDX_GRD))   nxt_gr[3] = pwdata[15:0];
    end

    // A new event wins over a clear in the same cycle
    nxt_flags = (flags_ff & ~clr_mask) | {wrap_ev, cap_hit | match};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mstby_ff   <= CCT_RST_MSTBY;
      mode_ff    <= CCT_RST_MODE & ~CCT_ONES_MODE;
      ctrl1_ff   <= CCT_RST_CTRL1;
      ien_ff     <= CCT_RST_IEN & ~CCT_ONES_IEN;
      ioab_ff    <= CCT_RST_IOAB & ~CCT_ONES_IOAB;
      iocd_ff    <= CCT_RST_IOCD;
      flags_ff   <= 5'h00;
      armed_ff   <= 5'h00;
      cnt_ff     <= 16'h0000;
      for (int i = 0; i < 4; i++) begin
        gr_ff[i] <= 16'hffff;
      end
      div_ff     <= 5'h00;
    end else begin
      mstby_ff   <= nxt_mstby;
      mode_ff    <= nxt_mode;
      ctrl1_ff   <= nxt_ctrl1;
      ien_ff     <= nxt_ien;
      ioab_ff    <= nxt_ioab;
      iocd_ff    <= nxt_iocd;
      flags_ff   <= nxt_flags;
      armed_ff   <= nxt_armed;
      cnt_ff     <= nxt_cnt;
      gr_ff      <= nxt_gr;
      div_ff     <= nxt_div;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling
  always_comb begin
    nxt_sync1 = {slow_osc_div_signal, ext_count_clock_pin, channel_d_pin,
                 channel_c_pin, channel_b_pin, channel_a_pin};
    nxt_sync2 = sync1_ff;
    nxt_prev  = sync2_ff;
  end

  // Two stages before any edge logic; the third stage only remembers the old level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 6'h00;
      sync2_ff <= 6'h00;
      prev_ff  <= 6'h00;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      prev_ff  <= nxt_prev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus response
  always_comb begin
    nxt_pready  = access & ~pready_ff;
    nxt_prdata  = prdata_ff;
    nxt_pslverr = pslverr_ff;
    // One wait state: data and status are registered in the first access cycle
    if (access & ~pready_ff) begin
      nxt_prdata  = (blocked | ~mapped | pwrite) ? 32'h0000_0000 : {16'h0000, rd16};
      nxt_pslverr = blocked | ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Requests and clock enable
  always_comb begin
    nxt_irq    = flags_ff & {ien_ff[CCT_B_WRAP], ien_ff[3:0]};
    nxt_clk_on = ~sleeping;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff    <= 5'h00;
      clk_on_ff <= 1'b0;
    end else begin
      irq_ff    <= nxt_irq;
      clk_on_ff <= nxt_clk_on;
    end
  end

  assign prdata         = prdata_ff;
  assign pready         = pready_ff;
  assign pslverr        = pslverr_ff;
  assign chan_a_irq     = irq_ff[0];
  assign chan_b_irq     = irq_ff[1];
  assign chan_c_irq     = irq_ff[2];
  assign chan_d_irq     = irq_ff[3];
  assign wrap_irq       = irq_ff[4];
  assign timer_clock_on = clk_on_ff;

endmodule : cct_timer_ctrl

/* File: cct_timer_ctrl_monitor.sv */
`timescale 1ns/1ps

module cct_timer_ctrl_monitor
  import cct_pkg::*;
(
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [CCT_ADDR_W-1:0] paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  chan_a_irq,
  input wire logic                  wrap_irq,
  input wire logic                  timer_clock_on
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic       done;
  logic [9:0] idx;
  logic       in_rng;
  assign done   = psel && penable && pready;
  assign idx    = paddr[CCT_ADDR_W-1:2];
  assign in_rng = (idx >= CCT_IDX_LO) && (idx <= CCT_IDX_HI);

  ////////////////////////////////////////////////////////////
  a_ready_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("pready not one wait state after access start");
  a_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready outside access or longer than one cycle");
  a_wr_rdata_zero: assert property (done && pwrite |-> prdata == 32'h0)
    else $error("prdata not zero on write completion");
  a_unmapped_err: assert property (done && (idx == 10'h130 || idx == 10'h000) |-> pslverr)
    else $error("unmapped access without error");
  a_sleep_clock: assert property (
    done && pwrite && idx == CCT_IDX_MSTBY |=> ##1
    (timer_clock_on == !$past(pwdata[CCT_B_SLEEP], 2)))
    else $error("timer clock enable does not follow standby bit");
  a_blocked_err: assert property (done && in_rng && !timer_clock_on |-> pslverr)
    else $error("access in standby not refused");
  a_blocked_rd: assert property (done && !pwrite && in_rng && !timer_clock_on |-> prdata == 0)
    else $error("read in standby returned data");
  a_awake_ok: assert property (done && idx <= CCT_IDX_IOCD && idx >= CCT_IDX_LO &&
    timer_clock_on |-> !pslverr)
    else $error("control register access refused while awake");
  a_mask_chan_a: assert property (
    done && pwrite && idx == CCT_IDX_IEN && !pwdata[0] |=> ##1 !chan_a_irq)
    else $error("channel A request while disabled");
  a_mask_wrap: assert property (
    done && pwrite && idx == CCT_IDX_IEN && !pwdata[CCT_B_WRAP] |=> ##1 !wrap_irq)
    else $error("wrap request while disabled");
endmodule : cct_timer_ctrl_monitor

bind cct_timer_ctrl cct_timer_ctrl_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .chan_a_irq(chan_a_irq), .wrap_irq(wrap_irq), .timer_clock_on(timer_clock_on)
);

/* File: tb_cct_timer_ctrl.sv */
`timescale 1ns/1ps

module tb_cct_timer_ctrl;
  import cct_pkg::*;
  logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr, er, clk_on;
  logic [CCT_ADDR_W-1:0] paddr;
  logic [31:0]           pwdata, prdata, rd;
  logic                  ext_pin, pin_a, pin_b, pin_c, pin_d, osc;
  logic [4:0]            irq;
  int                    err_count, n_compared, cyc;

  localparam logic [9:0] RIDX [12] = '{CCT_IDX_MSTBY, CCT_IDX_MODE, CCT_IDX_CTRL1, CCT_IDX_IEN,
    CCT_IDX_FLAGS, CCT_IDX_IOAB, CCT_IDX_IOCD, CCT_IDX_CNT, CCT_IDX_GRA, CCT_IDX_GRB,
    CCT_IDX_GRC, CCT_IDX_GRD};
  localparam logic [31:0] REXP [12] = '{32'h00, 32'h48, 32'h00, 32'h70, 32'h70, 32'h80,
    32'h88, 32'h0, 32'hffff, 32'hffff, 32'hffff, 32'hffff};

  cct_timer_ctrl DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_count_clock_pin(ext_pin), .channel_a_pin(pin_a), .channel_b_pin(pin_b),
    .channel_c_pin(pin_c), .channel_d_pin(pin_d), .slow_osc_div_signal(osc),
    .chan_a_irq(irq[0]), .chan_b_irq(irq[1]), .chan_c_irq(irq[2]), .chan_d_irq(irq[3]),
    .wrap_irq(irq[4]), .timer_clock_on(clk_on)
  );

  always #25 pclk = ~pclk;

  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // APB master: holds the request until pready is sampled high
  task automatic xfer(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'h0};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic rchk(input logic [9:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    chk($sformatf("reg %h", idx), exp, rd);
  endtask : rchk

  // Bounded wait so a stuck request cannot hang the run
  task automatic wirq(input int i, input logic exp);
    int n;
    n = 0;
    while (irq[i] !== exp && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk($sformatf("irq %0d", i), {31'h0, exp}, {31'h0, irq[i]});
  endtask : wirq

  task automatic summarize();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      $display("[ERR] run_cycles expected %0d seen %0d", 19999, cyc);
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    ext_pin = 0; pin_a = 0; pin_b = 0; pin_c = 0; pin_d = 0; osc = 0;
    err_count = 0; n_compared = 0; cyc = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 12; i++) rchk(RIDX[i], REXP[i]);
    rchk(10'h130, 32'h0);
    chk("pslverr", 32'h1, {31'h0, er});
    $display("test reset_values done");

    xfer(1'b1, CCT_IDX_MODE, 32'h3f);
    rchk(CCT_IDX_MODE, 32'h7f);
    xfer(1'b1, CCT_IDX_IEN, 32'h0);
    rchk(CCT_IDX_IEN, 32'h70);
    xfer(1'b1, CCT_IDX_IOAB, 32'h0);
    rchk(CCT_IDX_IOAB, 32'h80);
    xfer(1'b1, CCT_IDX_MODE, 32'h08);
    $display("test unassigned_bits done");

    xfer(1'b1, CCT_IDX_MSTBY, 32'h20);
    repeat (2) @(posedge pclk);
    chk("timer_clock_on", 32'h0, {31'h0, clk_on});
    xfer(1'b1, CCT_IDX_MODE, 32'h3f);
    chk("pslverr", 32'h1, {31'h0, er});
    rchk(CCT_IDX_MODE, 32'h0);
    xfer(1'b1, CCT_IDX_MSTBY, 32'h0);
    rchk(CCT_IDX_MODE, 32'h48);
    chk("timer_clock_on", 32'h1, {31'h0, clk_on});
    $display("test standby done");

    xfer(1'b1, CCT_IDX_GRA, 32'h10);
    xfer(1'b1, CCT_IDX_IEN, 32'h01);
    xfer(1'b1, CCT_IDX_MODE, 32'h88);
    wirq(0, 1'b1);
    xfer(1'b1, CCT_IDX_MODE, 32'h08);
    xfer(1'b1, CCT_IDX_FLAGS, 32'h0);
    rchk(CCT_IDX_FLAGS, 32'h71);
    xfer(1'b1, CCT_IDX_FLAGS, 32'h01);
    rchk(CCT_IDX_FLAGS, 32'h71);
    xfer(1'b1, CCT_IDX_FLAGS, 32'h0);
    rchk(CCT_IDX_FLAGS, 32'h70);
    wirq(0, 1'b0);
    $display("test compare_flags done");

    xfer(1'b1, CCT_IDX_CNT, 32'hfff0);
    xfer(1'b1, CCT_IDX_IEN, 32'h80);
    xfer(1'b1, CCT_IDX_MODE, 32'hb8);
    wirq(4, 1'b1);
    wirq(1, 1'b0);
    wirq(2, 1'b0);
    wirq(3, 1'b0);
    xfer(1'b1, CCT_IDX_MODE, 32'h08);
    xfer(1'b0, CCT_IDX_FLAGS, 32'h0);
    chk("wrap_flag", 32'h80, rd & 32'h80);
    chk("flags", 32'hfe, rd);
    xfer(1'b1, CCT_IDX_FLAGS, 32'h0);
    wirq(4, 1'b0);
    $display("test overflow done");

    xfer(1'b1, CCT_IDX_IOAB, 32'h40);
    xfer(1'b1, CCT_IDX_IEN, 32'h02);
    xfer(1'b1, CCT_IDX_MODE, 32'h88);
    repeat (10) @(posedge pclk);
    wirq(1, 1'b0);
    @(posedge pclk) pin_b <= 1'b1;
    wirq(1, 1'b1);
    $display("test capture done");

    xfer(1'b1, CCT_IDX_MODE, 32'h08);
    xfer(1'b1, CCT_IDX_CTRL1, 32'h50);
    xfer(1'b1, CCT_IDX_CNT, 32'h0);
    xfer(1'b1, CCT_IDX_MODE, 32'h88);
    // Pulses wider than three clocks so the synchroniser sees each one
    repeat (3) begin
      @(posedge pclk) ext_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      ext_pin <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    repeat (6) @(posedge pclk);
    xfer(1'b1, CCT_IDX_MODE, 32'h08);
    rchk(CCT_IDX_CNT, 32'h3);
    $display("test ext_source done");
    summarize();
  end
endmodule : tb_cct_timer_ctrl
